/* rtl/sgc_pkg.sv */
/*
 Package for the switch global control block: register offsets, field
 positions, reset values, timing constants and carrier structs.
 Assumes an 8-bit register port with byte offsets, one clock at 50 MHz.
*/
`default_nettype none
package sgc_pkg;
	localparam logic [7:0] GC0_OFFSET      = 8'h02;
	localparam logic [7:0] GC1_OFFSET      = 8'h03;
	localparam int         BIT_BACKOFF     = 7;
	localparam int         BIT_RSVD6       = 6;
	localparam int         BIT_DYN_PURGE   = 5;
	localparam int         BIT_STAT_PURGE  = 4;
	localparam int         BIT_RSVD3       = 3;
	localparam int         BIT_RSVD2       = 2;
	localparam int         BIT_DROP_MODE   = 1;
	localparam int         BIT_LINK_AGE    = 0;
	localparam int         BIT_PASS_ALL    = 7;
	localparam int         BIT_LONG_FRAME  = 6;
	localparam logic [7:0] GC0_RESET       = 8'h0C;
	localparam logic [7:0] GC0_RSVD_VALUE  = 8'h0C;
	localparam logic [7:0] GC0_RW_MASK     = 8'h83;
	localparam logic [7:0] GC1_RESET       = 8'h00;
	localparam logic [7:0] GC1_RW_MASK     = 8'hC0;
	localparam int         NUM_PORTS       = 4;
	localparam logic [15:0] PAUSE_TYPE     = 16'h8808;
	localparam logic [47:0] PAUSE_DA       = 48'h0180C2000001;
	localparam int         CLK_MHZ         = 50;
	localparam int         FAST_AGE_US     = 800;
	localparam int         FAST_AGE_CYC    = FAST_AGE_US * CLK_MHZ;
	localparam int         NORMAL_AGE_S    = 300;
	localparam int         CNT_W           = 32;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} sgc_reg_req_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] type_len;
		logic [47:0] dest_addr;
		logic        is_flow_ctrl;
	} sgc_frame_info_type;

	typedef struct packed {
		logic alt_backoff_en;
		logic conformance_drop_mode;
		logic pass_all_frames;
		logic long_frame_enable;
	} sgc_ctrl_type;
endpackage
`default_nettype wire

/* rtl/sgc_global_control.sv */
/*
 Global control registers 0x02 and 0x03 of the switch: purge triggers,
 drop-mode frame filter, link-change fast aging timer and mode bits.
 Assumes link_up is synchronous to mclk; table engines take purge pulses.
*/
//
// Contract
// - GC0 bit 7 enables alternative half-duplex back-off, reset zero.
// - Writing one to GC0 bit 5 pulses dynamic purge, bit self-clears.
// - Dynamic purge removes only entries of learning-disabled ports.
// - Writing one to GC0 bit 4 pulses static purge, bit self-clears.
// - Static match: single forwarding port, unicast, that port learning-disabled.
// - Drop mode set drops type 0x8808 or DA 01-80-C2-00-00-01.
// - Drop mode clear drops only qualified flow-control frames.
// - GC0 bit 0 set, link-down edge starts fast aging under 800 us; the timer here runs FAST_AGE_CYC cycles, exactly 800 us at 50 MHz.
// - After fast aging completes, aging returns to normal period.
// - Link-change aging active and port unplugged ages out all addresses.
// - GC1 bit 7 forwards all frames including errored ones.
// - GC1 bit 6 enables frames up to 2K bytes, reset zero.
`timescale 1ns/1ns
`default_nettype none
module sgc_global_control #(
	parameter int FAST_AGE_CYCLES = sgc_pkg::FAST_AGE_CYC
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire sgc_pkg::sgc_reg_req_type    reg_req,
	output logic [7:0]                       reg_rdata,
	input  wire logic [sgc_pkg::NUM_PORTS-1:0] link_up,
	input  wire logic [sgc_pkg::NUM_PORTS-1:0] learn_disable,
	input  wire sgc_pkg::sgc_frame_info_type frame_info,
	output logic                             frame_drop,
	output logic                             dyn_table_purge,
	output logic                             static_table_purge,
	output logic [sgc_pkg::NUM_PORTS-1:0]    purge_port_mask,
	output logic                             fast_age_active,
	output logic                             fast_age_done,
	output sgc_pkg::sgc_ctrl_type            ctrl
);
	import sgc_pkg::*;

	typedef enum logic [0:0] {
		AGE_NORMAL = 1'b0,
		AGE_FAST   = 1'b1
	} sgc_age_state_type;

	logic [7:0]              gc0_reg;
	logic [7:0]              gc0_next;
	logic [7:0]              gc1_reg;
	logic [7:0]              gc1_next;
	logic [7:0]              rdata_reg;
	logic [7:0]              rdata_next;
	logic                    dyn_reg;
	logic                    dyn_next;
	logic                    stat_reg;
	logic                    stat_next;
	logic [NUM_PORTS-1:0]    mask_reg;
	logic [NUM_PORTS-1:0]    mask_next;
	logic                    drop_reg;
	logic                    drop_next;
	logic [NUM_PORTS-1:0]    link_reg;
	logic [NUM_PORTS-1:0]    link_next;
	sgc_age_state_type       age_reg;
	sgc_age_state_type       age_next;
	logic [CNT_W-1:0]        cnt_reg;
	logic [CNT_W-1:0]        cnt_next;
	logic                    done_reg;
	logic                    done_next;
	logic                    wr0;
	logic                    wr1;
	logic                    link_lost;

	assign wr0       = reg_req.wr && (reg_req.addr == GC0_OFFSET);
	assign wr1       = reg_req.wr && (reg_req.addr == GC1_OFFSET);
	assign link_lost = |(link_reg & ~link_up);

	// Register file and purge triggers
	always_comb
	begin
		gc0_next  = gc0_reg;
		gc1_next  = gc1_reg;
		dyn_next  = 1'b0;
		stat_next = 1'b0;
		mask_next = mask_reg;
		if (wr0)
		begin
			gc0_next = (reg_req.wdata & GC0_RW_MASK) | GC0_RSVD_VALUE;
			dyn_next  = reg_req.wdata[BIT_DYN_PURGE];
			stat_next = reg_req.wdata[BIT_STAT_PURGE];
			if (reg_req.wdata[BIT_DYN_PURGE] || reg_req.wdata[BIT_STAT_PURGE])
			begin
				mask_next = learn_disable;
			end
		end
		if (wr1)
		begin
			gc1_next = reg_req.wdata & GC1_RW_MASK;
		end
		rdata_next = rdata_reg;
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				GC0_OFFSET: rdata_next = gc0_reg;
				GC1_OFFSET: rdata_next = gc1_reg;
				default:    rdata_next = 8'h00;
			endcase
		end
	end

	// Frame drop filter
	always_comb
	begin
		drop_next = 1'b0;
		if (frame_info.valid && !gc1_reg[BIT_PASS_ALL])
		begin
			if (gc0_reg[BIT_DROP_MODE])
			begin
				drop_next = (frame_info.type_len == PAUSE_TYPE)
					|| (frame_info.dest_addr == PAUSE_DA);
			end
			else
			begin
				drop_next = frame_info.is_flow_ctrl;
			end
		end
	end

	// Link-change fast aging
	always_comb
	begin
		link_next = link_up;
		age_next  = age_reg;
		cnt_next  = cnt_reg;
		done_next = 1'b0;
		case (age_reg)
			AGE_NORMAL:
			begin
				if (gc0_reg[BIT_LINK_AGE] && link_lost)
				begin
					age_next = AGE_FAST;
					cnt_next = CNT_W'(FAST_AGE_CYCLES - 1);
				end
			end
			AGE_FAST:
			begin
				if (cnt_reg == '0)
				begin
					age_next  = AGE_NORMAL;
					done_next = 1'b1;
				end
				else
				begin
					cnt_next = cnt_reg - CNT_W'(1);
				end
			end
			default:
			begin
				age_next = AGE_NORMAL;
			end
		endcase
	end

	// Register file and purge state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			gc0_reg   <= GC0_RESET;
			gc1_reg   <= GC1_RESET;
			rdata_reg <= 8'h00;
			dyn_reg   <= 1'b0;
			stat_reg  <= 1'b0;
			mask_reg  <= '0;
		end
		else
		begin
			gc0_reg   <= gc0_next;
			gc1_reg   <= gc1_next;
			rdata_reg <= rdata_next;
			dyn_reg   <= dyn_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
		end
	end

	// Frame filter state
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			drop_reg <= 1'b0;
		end
		else
		begin
			drop_reg <= drop_next;
		end
	end

	// Fast aging state; link history cleared so reset never looks like a link loss
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			link_reg <= '0;
			age_reg  <= AGE_NORMAL;
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			link_reg <= link_next;
			age_reg  <= age_next;
			cnt_reg  <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign reg_rdata                  = rdata_reg;
	assign frame_drop                 = drop_reg;
	assign dyn_table_purge            = dyn_reg;
	assign static_table_purge         = stat_reg;
	assign purge_port_mask            = mask_reg;
	assign fast_age_active            = (age_reg == AGE_FAST);
	assign fast_age_done              = done_reg;
	assign ctrl.alt_backoff_en        = gc0_reg[BIT_BACKOFF];
	assign ctrl.conformance_drop_mode = gc0_reg[BIT_DROP_MODE];
	assign ctrl.pass_all_frames       = gc1_reg[BIT_PASS_ALL];
	assign ctrl.long_frame_enable     = gc1_reg[BIT_LONG_FRAME];
endmodule
`default_nettype wire

/* tb/sgc_checker.sv */
/* Checker for sgc_global_control ports.
 Bound into each design instance; one clock. */
`timescale 1ns/1ns
`default_nettype none
module sgc_checker #(
	parameter int FAST_AGE_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire sgc_pkg::sgc_reg_req_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] learn_disable,
	input wire sgc_pkg::sgc_frame_info_type frame_info,
	input wire logic frame_drop,
	input wire logic dyn_table_purge,
	input wire logic static_table_purge,
	input wire logic [3:0] purge_port_mask,
	input wire logic fast_age_active,
	input wire logic fast_age_done,
	input wire sgc_pkg::sgc_ctrl_type ctrl
);
	import sgc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic w0 = reg_req.wr && reg_req.addr == GC0_OFFSET;
	wire logic fv = frame_info.valid && !ctrl.pass_all_frames;
	logic [CNT_W-1:0] age_cnt;
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !fast_age_active)
			age_cnt <= '0;
		else
			age_cnt <= age_cnt + CNT_W'(1);
	end
	a_dyn_pulse: assert property (w0 && reg_req.wdata[5] |=> dyn_table_purge ##1
		(!dyn_table_purge || $past(w0 && reg_req.wdata[5]))) else $error("dyn purge pulse");
	a_stat_clear: assert property (static_table_purge |-> $past(w0 && reg_req.wdata[4]))
		else $error("static purge not cleared");
	a_stat_mask: assert property (w0 && reg_req.wdata[4] |=> static_table_purge
		&& purge_port_mask == $past(learn_disable)) else $error("static purge");
	a_drop_match: assert property (fv && ctrl.conformance_drop_mode &&
		(frame_info.type_len == PAUSE_TYPE || frame_info.dest_addr == PAUSE_DA) |=> frame_drop)
		else $error("no drop");
	a_flow_drop: assert property (fv && !ctrl.conformance_drop_mode |=>
		frame_drop == $past(frame_info.is_flow_ctrl)) else $error("flow drop");
	a_pass_all: assert property (frame_info.valid && ctrl.pass_all_frames |=> !frame_drop)
		else $error("pass all");
	a_age_len: assert property ($fell(fast_age_active) |-> fast_age_done &&
		age_cnt == CNT_W'(FAST_AGE_CYCLES)) else $error("age length");
	a_age_bound: assert property (fast_age_active |-> age_cnt < CNT_W'(FAST_AGE_CYCLES))
		else $error("age too long");
	a_rsvd_read: assert property (reg_req.rd && reg_req.addr == GC0_OFFSET |=>
		reg_rdata[6:2] == 5'h03) else $error("reserved bits");
	a_backoff_bit: assert property (w0 |=> ctrl.alt_backoff_en == $past(reg_req.wdata[7]))
		else $error("backoff bit");
	a_long_frame: assert property (reg_req.wr && reg_req.addr == GC1_OFFSET |=>
		ctrl.long_frame_enable == $past(reg_req.wdata[6])) else $error("long frame");
endmodule
bind sgc_global_control sgc_checker #(.FAST_AGE_CYCLES(FAST_AGE_CYCLES)) sgc_checker_i
(
	.mclk               (mclk),
	.rst_n              (rst_n),
	.reg_req            (reg_req),
	.reg_rdata          (reg_rdata),
	.learn_disable      (learn_disable),
	.frame_info         (frame_info),
	.frame_drop         (frame_drop),
	.dyn_table_purge    (dyn_table_purge),
	.static_table_purge (static_table_purge),
	.purge_port_mask    (purge_port_mask),
	.fast_age_active    (fast_age_active),
	.fast_age_done      (fast_age_done),
	.ctrl               (ctrl)
);
`default_nettype wire

/* tb/sgc_global_control_tb.sv */
/* Testbench for sgc_global_control.
 Drives every port itself at 50 MHz. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module sgc_global_control_tb;
	import sgc_pkg::*;
	logic mclk = 0;
	logic rst_n = 0;
	sgc_reg_req_type reg_req = '0;
	logic [3:0] link_up = 4'hF;
	logic [3:0] learn_disable = 4'hA;
	sgc_frame_info_type frame_info = '0;
	logic [7:0] reg_rdata;
	logic [3:0] purge_port_mask;
	logic frame_drop, dyn_table_purge, static_table_purge, fast_age_active, fast_age_done;
	sgc_ctrl_type ctrl;
	int failures = 0;
	int samples_checked = 0;
	int n;
	sgc_global_control #(.FAST_AGE_CYCLES(8)) sgc_global_control_i
	(
		.mclk               (mclk),
		.rst_n              (rst_n),
		.reg_req            (reg_req),
		.reg_rdata          (reg_rdata),
		.link_up            (link_up),
		.learn_disable      (learn_disable),
		.frame_info         (frame_info),
		.frame_drop         (frame_drop),
		.dyn_table_purge    (dyn_table_purge),
		.static_table_purge (static_table_purge),
		.purge_port_mask    (purge_port_mask),
		.fast_age_active    (fast_age_active),
		.fast_age_done      (fast_age_done),
		.ctrl               (ctrl)
	);
	always #10 mclk = ~mclk;
	task automatic wr(input logic [7:0] a, d);
		@(posedge mclk) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge mclk) reg_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge mclk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge mclk) reg_req <= '0;
		#1 `CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic fr(input logic [15:0] t, input logic [47:0] da, input logic fc, e);
		@(posedge mclk) frame_info <= '{1'b1, t, da, fc};
		@(posedge mclk) frame_info <= '0;
		#1 `CHK("frame_drop", e, frame_drop)
	endtask
	task automatic report_and_stop;
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge mclk);
		failures++;
		report_and_stop;
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(GC0_OFFSET, 8'h0C);
		rd(GC1_OFFSET, 8'h00);
		wr(GC0_OFFSET, 8'hFF);
		`CHK("purge", 2'b11, {dyn_table_purge, static_table_purge})
		`CHK("purge_port_mask", 4'hA, purge_port_mask)
		`CHK("ctrl", 4'hC, ctrl)
		@(posedge mclk) #1 `CHK("purge", 2'b00, {dyn_table_purge, static_table_purge})
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00);
		rd(GC0_OFFSET, 8'h8F);
		wr(GC0_OFFSET, 8'h7E);
		rd(GC0_OFFSET, 8'h0E);
		wr(GC1_OFFSET, 8'hC0);
		rd(GC1_OFFSET, 8'hC0);
		`CHK("ctrl", 4'h7, ctrl)
		fr(PAUSE_TYPE, 48'h0, 1'b1, 1'b0);
		wr(GC1_OFFSET, 8'h00);
		fr(PAUSE_TYPE, 48'h0, 1'b0, 1'b1);
		fr(16'h0800, PAUSE_DA, 1'b0, 1'b1);
		fr(16'h0800, 48'h0, 1'b0, 1'b0);
		wr(GC0_OFFSET, 8'h01);
		`CHK("ctrl", 4'h0, ctrl)
		fr(16'h0800, 48'h0, 1'b1, 1'b1);
		fr(PAUSE_TYPE, PAUSE_DA, 1'b0, 1'b0);
		@(posedge mclk) link_up <= 4'hE;
		@(posedge mclk) #1 `CHK("fast_age_active", 1'b1, fast_age_active)
		n = 0;
		while (fast_age_active === 1'b1)
		begin
			n++;
			@(posedge mclk) #1;
		end
		`CHK("fast_age_len", 8, n)
		`CHK("fast_age_done", 1'b1, fast_age_done)
		report_and_stop;
	end
endmodule
`default_nettype wire
